// file: inc/ucrd_pkg.sv
`default_nettype none

package ucrd_pkg;

  // ****************************************************************
  // Register offsets (byte-wide registers, one per address)
  // ****************************************************************
  localparam logic [3:0] OFF_DIV_LOW = 4'h0;      // Low divisor byte
  localparam logic [3:0] OFF_DIV_HIGH = 4'h1;     // divisor_high_byte
  localparam logic [3:0] OFF_FRAC_DIV = 4'h2;     // fractional_divisor
  localparam logic [3:0] OFF_IRQ_EN = 4'h3;       // Interrupt enable
  localparam logic [3:0] OFF_FIFO_CTL = 4'h4;     // FIFO control
  localparam logic [3:0] OFF_LINE_CTL = 4'h5;     // Line control
  localparam logic [3:0] OFF_MODEM_CTL = 4'h6;    // Modem control
  localparam logic [3:0] OFF_SCRATCH = 4'h7;      // Scratch pad
  localparam logic [3:0] OFF_ENH_FEAT = 4'h8;     // Enhanced feature
  localparam logic [3:0] OFF_RESUME_ONE = 4'h9;   // resume_char_one
  localparam logic [3:0] OFF_RESUME_TWO = 4'hA;   // resume_char_two
  localparam logic [3:0] OFF_STOP_ONE = 4'hB;     // stop_char_one
  localparam logic [3:0] OFF_STOP_TWO = 4'hC;     // stop_char_two
  localparam logic [3:0] OFF_MODEM_STAT = 4'hD;   // modem_status_reg (read only)
  localparam logic [3:0] OFF_IRQ_STAT = 4'hE;     // Interrupt status (read only)
  localparam logic [3:0] OFF_LINE_STAT = 4'hF;    // Line status (read only)

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_DIV_LOW = 8'h01;     // Power-up only
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;    // Power-up only
  localparam logic [7:0] RST_ZERO = 8'h00;        // Most control registers
  localparam logic [7:0] RST_IRQ_STAT = 8'h01;    // No interrupt pending
  localparam logic [7:0] RST_LINE_STAT = 8'h60;   // Transmitter empty
  localparam logic [7:0] RST_SCRATCH = 8'hFF;     // Scratch pad default

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int STAT_DELTA_LSB = 0;              // Change indicators 3:0
  localparam int STAT_LEVEL_LSB = 4;              // Inverted input levels 7:4
  localparam int ENH_EN_BIT = 4;                  // Enhanced write enable
  localparam int MCR_LOOP_BIT = 4;                // Loopback

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam logic [1:0] SYNC_PRIME_COUNT = 2'h3; // Edges before pin changes count

endpackage : ucrd_pkg

`default_nettype wire

// file: src/ucrd_reg8.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// One byte register with reset default and write enable
// ****************************************************************
module ucrd_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00  // Value under reset
) (
  input wire logic clk,          // Clock
  input wire logic rst,          // Async reset, active high
  input wire logic ce,           // Clock enable
  input wire logic wr_en,        // Write this byte
  input wire logic [7:0] wdata,  // Write data
  output logic [7:0] q           // Stored value
);

  logic [7:0] value_reg;  // Held byte

  // Loads on a write, returns to default on reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_reg <= RESET_VALUE;
    end else if (ce && wr_en) begin
      value_reg <= wdata;
    end
  end

  assign q = value_reg;

endmodule : ucrd_reg8

`default_nettype wire

// file: src/ucrd_top.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1 - Four read/write flow control character registers
// RULE2 - Power-up divisor high 00, low 01
// RULE3 - Reset pin leaves divisor bytes unchanged
// RULE4 - Reset: status deltas zero, levels inverted
// RULE5 - Reset pin restores all other defaults
module ucrd_top (
  input wire logic CLK,             // 200 MHz clock
  input wire logic RST,             // Reset pin, async, active high
  input wire logic POR,             // Power-on reset, async, active high
  input wire logic CE,              // Clock enable, freezes state when low
  input wire logic [3:0] ADDR,      // Register address
  input wire logic [7:0] WDATA,     // Write data
  input wire logic WR,              // Write strobe
  input wire logic RD,              // Read strobe
  output logic [7:0] RDATA,         // Read data, valid cycle after RD
  input wire logic CTS_N,           // Clear to send pin, active low
  input wire logic DSR_N,           // Data set ready pin, active low
  input wire logic RI_N,            // Ring indicator pin, active low
  input wire logic CD_N,            // Carrier detect pin, active low
  output logic [15:0] DIVISOR,      // Integer baud divisor
  output logic [7:0] FRAC_DIVISOR,  // Fractional divisor and sample rate
  output logic [7:0] RESUME_ONE,    // resume_char_one to the flow logic
  output logic [7:0] RESUME_TWO,    // resume_char_two to the flow logic
  output logic [7:0] STOP_ONE,      // stop_char_one to the flow logic
  output logic [7:0] STOP_TWO,      // stop_char_two to the flow logic
  output logic [7:0] ENH_FEATURE    // Enhanced feature byte
);

  // ****************************************************************
  // Input synchronisers for modem pins
  // ****************************************************************
  logic [3:0] modem_meta_reg;   // First stage, read only by second
  logic [3:0] modem_sync_reg;   // Second stage, safe to use
  logic [3:0] modem_prev_reg;   // Last sampled level for change detect
  logic [1:0] prime_cnt_reg;    // Edges since reset, saturates
  logic primed;                 // Sync stages and previous sample are real

  // Two-flop crossing; pins are asynchronous to CLK
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      modem_meta_reg <= 4'h0;
      modem_sync_reg <= 4'h0;
    end else if (CE) begin
      modem_meta_reg <= {CD_N, RI_N, DSR_N, CTS_N};
      modem_sync_reg <= modem_meta_reg;
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  logic wr_any;        // Accepted write
  logic enh_open;      // Enhanced bits writable
  logic [7:0] enh_q;   // Enhanced feature register
  logic [7:0] mcr_q;   // Modem control register

  assign wr_any = WR && !RD;
  assign enh_open = enh_q[ucrd_pkg::ENH_EN_BIT];

  // ****************************************************************
  // Baud divisor latch, power-up only
  // ****************************************************************
  logic [7:0] div_low_reg;   // Low divisor byte
  logic [7:0] div_high_reg;  // divisor_high_byte

  // Only POR touches these; the reset pin is deliberately not in the list
  always_ff @(posedge CLK or posedge POR) begin
    if (POR) begin
      div_low_reg <= ucrd_pkg::RST_DIV_LOW;    // RULE2
      div_high_reg <= ucrd_pkg::RST_DIV_HIGH;  // RULE2
    end else if (CE && wr_any) begin
      // Writes still land while RST is high; RST does not clear them
      if (ADDR == ucrd_pkg::OFF_DIV_LOW) begin  // RULE3
        div_low_reg <= WDATA;
      end
      if (ADDR == ucrd_pkg::OFF_DIV_HIGH) begin  // RULE3
        div_high_reg <= WDATA;
      end
    end
  end

  // ****************************************************************
  // Reset-pin control registers
  // ****************************************************************
  logic [7:0] frac_q;     // fractional_divisor
  logic [7:0] ier_q;      // Interrupt enable
  logic [7:0] fcr_q;      // FIFO control
  logic [7:0] lcr_q;      // Line control
  logic [7:0] spr_q;      // Scratch pad
  logic [7:0] res1_q;     // resume_char_one
  logic [7:0] res2_q;     // resume_char_two
  logic [7:0] stop1_q;    // stop_char_one
  logic [7:0] stop2_q;    // stop_char_two
  logic rst_any;          // Either reset source

  // Power-up also restores every reset-pin default except the modem sync stages
  assign rst_any = RST | POR;

  // Fractional divisor is guarded by the enhanced enable bit
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_frac (  // RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && enh_open && ADDR == ucrd_pkg::OFF_FRAC_DIV),
    .wdata(WDATA),
    .q(frac_q)
  );
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_ier (  // RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_IRQ_EN),
    .wdata(WDATA),
    .q(ier_q)
  );
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_fcr (  // RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_FIFO_CTL),
    .wdata(WDATA),
    .q(fcr_q)
  );
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_lcr (  // RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_LINE_CTL),
    .wdata(WDATA),
    .q(lcr_q)
  );
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_mcr (  // RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_MODEM_CTL),
    .wdata(WDATA),
    .q(mcr_q)
  );
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_SCRATCH)) u_spr (  // RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_SCRATCH),
    .wdata(WDATA),
    .q(spr_q)
  );
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_efr (  // RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_ENH_FEAT),
    .wdata(WDATA),
    .q(enh_q)
  );

  // Flow control characters, plain read/write bytes
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_res1 (  // RULE1 RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_RESUME_ONE),
    .wdata(WDATA),
    .q(res1_q)
  );
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_res2 (  // RULE1 RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_RESUME_TWO),
    .wdata(WDATA),
    .q(res2_q)
  );
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_stop1 (  // RULE1 RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_STOP_ONE),
    .wdata(WDATA),
    .q(stop1_q)
  );
  ucrd_reg8 #(.RESET_VALUE(ucrd_pkg::RST_ZERO)) u_stop2 (  // RULE1 RULE5
    .clk(CLK),
    .rst(rst_any),
    .ce(CE),
    .wr_en(wr_any && ADDR == ucrd_pkg::OFF_STOP_TWO),
    .wdata(WDATA),
    .q(stop2_q)
  );

  // ****************************************************************
  // Modem status register
  // ****************************************************************
  logic [3:0] stat_delta_reg;  // Sticky change indicators
  logic [3:0] stat_level;      // Inverted live levels
  logic [3:0] stat_change;     // Edge seen this cycle
  logic stat_read;             // Read clears the indicators

  // Upper nibble is the inverted pin level, never stored
  assign stat_level = ~modem_sync_reg;  // RULE4
  assign primed = (prime_cnt_reg == ucrd_pkg::SYNC_PRIME_COUNT);
  assign stat_change = primed ? (modem_sync_reg ^ modem_prev_reg) : 4'h0;  // RULE4
  assign stat_read = RD && !WR && ADDR == ucrd_pkg::OFF_MODEM_STAT;

  // Previous level tracker; the sync stages hold reset zeros, not pin levels,
  // for two edges, so nothing is compared until both stages are real
  always_ff @(posedge CLK or posedge rst_any) begin
    if (rst_any) begin
      modem_prev_reg <= 4'h0;
      prime_cnt_reg <= 2'h0;
    end else if (CE) begin
      modem_prev_reg <= modem_sync_reg;
      if (!primed) begin
        prime_cnt_reg <= prime_cnt_reg + 2'h1;
      end
    end
  end

  // Indicators clear on reset and on read; a new change beats the read
  always_ff @(posedge CLK or posedge rst_any) begin
    if (rst_any) begin
      stat_delta_reg <= 4'h0;  // RULE4
    end else if (CE) begin
      stat_delta_reg <= (stat_read ? 4'h0 : stat_delta_reg) | stat_change;
    end
  end

  // ****************************************************************
  // Read port, data one cycle after the strobe
  // ****************************************************************
  logic [7:0] rd_mux;  // Selected byte

  // Unmapped addresses cannot occur: all sixteen are used
  always_comb begin
    case (ADDR)
      ucrd_pkg::OFF_DIV_LOW: rd_mux = div_low_reg;
      ucrd_pkg::OFF_DIV_HIGH: rd_mux = div_high_reg;
      ucrd_pkg::OFF_FRAC_DIV: rd_mux = frac_q;
      ucrd_pkg::OFF_IRQ_EN: rd_mux = ier_q;
      ucrd_pkg::OFF_FIFO_CTL: rd_mux = fcr_q;
      ucrd_pkg::OFF_LINE_CTL: rd_mux = lcr_q;
      ucrd_pkg::OFF_MODEM_CTL: rd_mux = mcr_q;
      ucrd_pkg::OFF_SCRATCH: rd_mux = spr_q;
      ucrd_pkg::OFF_ENH_FEAT: rd_mux = enh_q;
      ucrd_pkg::OFF_RESUME_ONE: rd_mux = res1_q;  // RULE1
      ucrd_pkg::OFF_RESUME_TWO: rd_mux = res2_q;  // RULE1
      ucrd_pkg::OFF_STOP_ONE: rd_mux = stop1_q;   // RULE1
      ucrd_pkg::OFF_STOP_TWO: rd_mux = stop2_q;   // RULE1
      ucrd_pkg::OFF_MODEM_STAT: rd_mux = {stat_level, stat_delta_reg};  // RULE4
      ucrd_pkg::OFF_IRQ_STAT: rd_mux = ucrd_pkg::RST_IRQ_STAT;
      ucrd_pkg::OFF_LINE_STAT: rd_mux = ucrd_pkg::RST_LINE_STAT;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data register; holds zero outside the answer cycle
  always_ff @(posedge CLK or posedge rst_any) begin
    if (rst_any) begin
      RDATA <= 8'h00;
    end else if (CE) begin
      RDATA <= (RD && !WR) ? rd_mux : 8'h00;
    end
  end

  // ****************************************************************
  // Configuration outputs
  // ****************************************************************
  assign DIVISOR = {div_high_reg, div_low_reg};
  assign FRAC_DIVISOR = frac_q;
  assign RESUME_ONE = res1_q;
  assign RESUME_TWO = res2_q;
  assign STOP_ONE = stop1_q;
  assign STOP_TWO = stop2_q;
  assign ENH_FEATURE = enh_q;

endmodule : ucrd_top

`default_nettype wire

// file: testbench/ucrd_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host processor on the register port
// ****************************************************************
module ucrd_host (
  input wire logic clk,       // Bench clock
  output logic [3:0] addr,    // Register address
  output logic [7:0] wdata,   // Write data
  output logic wr,            // Write strobe
  output logic rd             // Read strobe
);
  logic [7:0] exp_q [$];      // Read results expected, oldest first

  // Quiet bus at time zero
  initial begin
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // One write cycle; a following call may come at the very next edge
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
  endtask : wr_reg

  // One read cycle; the expected byte is noted for the monitor
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    exp_q.push_back(e);
  endtask : rd_reg

  // Release: lines flip so a stale value never looks valid
  task automatic idle();
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= ~addr;
    wdata <= ~wdata;
  endtask : idle
endmodule : ucrd_host

`default_nettype wire

// file: testbench/ucrd_chk.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Port checker
// ****************************************************************
module ucrd_chk (
  input wire logic CLK,                 // Clock
  input wire logic RST,                 // Reset pin
  input wire logic POR,                 // Power-on reset
  input wire logic CE,                  // Clock enable
  input wire logic [3:0] ADDR,          // Address
  input wire logic [7:0] WDATA,         // Write data
  input wire logic WR,                  // Write strobe
  input wire logic RD,                  // Read strobe
  input wire logic [7:0] RDATA,         // Read data
  input wire logic [15:0] DIVISOR,      // Divisor
  input wire logic [7:0] FRAC_DIVISOR,  // Fraction
  input wire logic [7:0] RESUME_ONE,    // Flow char
  input wire logic [7:0] STOP_TWO,      // Flow char
  input wire logic [7:0] ENH_FEATURE    // Feature byte
);
  default clocking cb @(posedge CLK); endclocking
  // A write that the block must take
  logic take_wr;
  assign take_wr = WR && CE && !RD;

  a_rdata_idle: assert property (disable iff (RST || POR) CE && !RD |=> RDATA == 8'h00)
    else $error("read data not zero");
  a_resume_write: assert property (disable iff (RST || POR)
    take_wr && ADDR == ucrd_pkg::OFF_RESUME_ONE |=> RESUME_ONE == $past(WDATA))
    else $error("resume char not written");
  a_stop_write: assert property (disable iff (RST || POR)
    take_wr && ADDR == ucrd_pkg::OFF_STOP_TWO |=> STOP_TWO == $past(WDATA))
    else $error("stop char not written");
  a_resume_read: assert property (disable iff (RST || POR)
    RD && CE && !WR && ADDR == ucrd_pkg::OFF_RESUME_ONE |=> RDATA == $past(RESUME_ONE))
    else $error("resume char read wrong");
  a_div_write: assert property (disable iff (RST || POR)
    take_wr && ADDR == ucrd_pkg::OFF_DIV_LOW |=> DIVISOR[7:0] == $past(WDATA))
    else $error("divisor low not written");
  a_div_hold: assert property (disable iff (POR) RST |=> $stable(DIVISOR))
    else $error("reset pin moved divisor");
  a_por_div: assert property (disable iff (1'b0) POR |=> DIVISOR == 16'h0001)
    else $error("power-up divisor wrong");
  a_rst_dflt: assert property (disable iff (1'b0) RST |=>
    {RESUME_ONE, STOP_TWO, FRAC_DIVISOR, ENH_FEATURE} == 32'h0000_0000)
    else $error("reset defaults wrong");
  c_rst_only: cover property (RST && !POR);
  c_frac_wr: cover property (take_wr && ADDR == ucrd_pkg::OFF_FRAC_DIV &&
    ENH_FEATURE[ucrd_pkg::ENH_EN_BIT]);
  c_back_rd: cover property (RD ##1 RD);
endmodule : ucrd_chk

bind ucrd_top ucrd_chk ucrd_chk_inst (.CLK(CLK), .RST(RST), .POR(POR), .CE(CE), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .DIVISOR(DIVISOR),
  .FRAC_DIVISOR(FRAC_DIVISOR), .RESUME_ONE(RESUME_ONE), .STOP_TWO(STOP_TWO),
  .ENH_FEATURE(ENH_FEATURE));

`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic CLK = 1'b0;            // 200 MHz clock
  logic RST = 1'b1;            // Reset pin
  logic POR = 1'b1;            // Power-on reset
  logic CE = 1'b1;             // Clock enable, dropped low for one write in the last test
  logic [3:0] pins_n = 4'h0;   // Modem pin levels, active low, changed only on purpose
  wire logic [3:0] ADDR;       // From host
  wire logic [7:0] WDATA;      // From host
  wire logic WR;               // From host
  wire logic RD;               // From host
  logic [7:0] RDATA, FRAC, R1, R2, S1, S2, EF;  // Block outputs
  logic [15:0] DIVISOR;        // Block divisor
  logic rd_seen = 1'b0;        // A read was taken last edge
  int fails = 0;               // Mismatches
  int total_checks = 0;        // Comparisons
  logic [7:0] v [16];          // Written values
  // Defaults after a full power-up; modem nibble is inverted asserted pins
  logic [7:0] dflt [16] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h01, 8'h60};

  initial forever #2.5 CLK = ~CLK;

  ucrd_host ucrd_host_inst (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD));
  ucrd_top ucrd_top_inst (.CLK(CLK), .RST(RST), .POR(POR), .CE(CE), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CTS_N(pins_n[0]), .DSR_N(pins_n[1]),
    .RI_N(pins_n[2]), .CD_N(pins_n[3]), .DIVISOR(DIVISOR), .FRAC_DIVISOR(FRAC),
    .RESUME_ONE(R1), .RESUME_TWO(R2), .STOP_ONE(S1), .STOP_TWO(S2), .ENH_FEATURE(EF));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // Read data is judged in the one cycle that it stands
  always @(posedge CLK) rd_seen <= RD & CE;
  always @(negedge CLK) begin
    if (rd_seen === 1'b1) check(RDATA, ucrd_host_inst.exp_q.pop_front());
  end

  // Pulse a reset; three idle edges let the modem pins settle through the sync
  task automatic pulse(input logic por);
    @(posedge CLK);
    RST <= 1'b1;
    POR <= por;
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    POR <= 1'b0;
    repeat (3) @(posedge CLK);
  endtask : pulse

  // Back-to-back reads of the whole map, divisor bytes as given
  task automatic read_map(input logic [7:0] lo, input logic [7:0] hi);
    for (int i = 0; i < 16; i++) begin
      ucrd_host_inst.rd_reg(4'(i), (i == 0) ? lo : (i == 1) ? hi : dflt[i]);
    end
    ucrd_host_inst.idle();
    repeat (2) @(posedge CLK);
  endtask : read_map

  initial begin
    #20000;
    fails++;
    complete_run();
  end

  initial begin
    void'($urandom(76));
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    POR <= 1'b0;
    repeat (3) @(posedge CLK);
    read_map(8'h01, 8'h00);
    $display("power-up defaults done");
    // Flow chars written back to back, then read back
    for (int i = 9; i < 13; i++) begin
      v[i] = 8'($urandom);
      ucrd_host_inst.wr_reg(4'(i), v[i]);
    end
    for (int i = 9; i < 13; i++) ucrd_host_inst.rd_reg(4'(i), v[i]);
    ucrd_host_inst.idle();
    check({R1, R2, S1, S2}, {v[9], v[10], v[11], v[12]});
    $display("flow chars done");
    // Divisor and unlocked fraction set, then the reset pin alone
    v[0] = 8'($urandom);
    v[1] = 8'($urandom);
    v[2] = 8'($urandom);
    ucrd_host_inst.wr_reg(4'h0, v[0]);
    ucrd_host_inst.wr_reg(4'h1, v[1]);
    ucrd_host_inst.wr_reg(4'h8, 8'h10);
    ucrd_host_inst.wr_reg(4'h2, v[2]);
    ucrd_host_inst.rd_reg(4'h2, v[2]);
    ucrd_host_inst.idle();
    check(DIVISOR, {v[1], v[0]});
    pulse(1'b0);
    check(DIVISOR, {v[1], v[0]});
    check({FRAC, EF}, 16'h0000);
    read_map(v[0], v[1]);
    $display("reset pin done");
    // New pin levels arrive just before the power-up reset; no change may be flagged
    v[13] = 8'($urandom);
    pins_n <= v[13][3:0];
    dflt[13] = {~v[13][3:0], 4'h0};
    pulse(1'b1);
    check(DIVISOR, 16'h0001);
    read_map(8'h01, 8'h00);
    $display("power cycle done");
    // A pin change after reset sets indicators; the read clears them
    v[14] = v[13] ^ 8'($urandom | 32'h0000_0001);
    pins_n <= v[14][3:0];
    repeat (4) @(posedge CLK);
    ucrd_host_inst.rd_reg(4'hD, {~v[14][3:0], v[13][3:0] ^ v[14][3:0]});
    ucrd_host_inst.rd_reg(4'hD, {~v[14][3:0], 4'h0});
    ucrd_host_inst.idle();
    repeat (2) @(posedge CLK);
    $display("modem changes done");
    // A write while the clock enable is low must be dropped
    CE <= 1'b0;
    ucrd_host_inst.wr_reg(4'h7, 8'h5A);
    ucrd_host_inst.idle();
    CE <= 1'b1;
    ucrd_host_inst.rd_reg(4'h7, 8'hFF);
    ucrd_host_inst.idle();
    repeat (2) @(posedge CLK);
    $display("clock enable done");
    complete_run();
  end
endmodule : tb

`default_nettype wire
